// ### design/instr_exec_regs.svh
// constants for the instruction execution subset: opcodes, fields, widths, resets
`ifndef INSTR_EXEC_REGS_SVH
`define INSTR_EXEC_REGS_SVH

// 14-bit instruction word fields
`define IW_WIDTH        14
`define IW_FADDR_MSB    6
`define IW_FADDR_LSB    0
`define IW_DEST_BIT     7
`define IW_K11_MSB      10
`define IW_K11_LSB      0
`define IW_OP6_MSB      13
`define IW_OP6_LSB      8
`define IW_OP3_MSB      13
`define IW_OP3_LSB      11

// major opcodes (upper six bits)
`define OP6_MISC        6'h00
`define OP6_CLEAR       6'h01
`define OP6_DECREMENT   6'h03
`define OP6_COMPLEMENT  6'h09
`define OP6_DEC_SKIP    6'h0B
// subroutine jump (upper three bits)
`define OP3_CALL        3'h4
// full words for fixed forms
`define IW_GUARD_CLEAR  14'h0064
`define IW_NOP          14'h0000

// destination select values
`define DEST_ACC        1'h0
`define DEST_FILE       1'h1

// widths and reset values
`define DATA_W          8
`define FADDR_W         7
`define PC_W            13
`define LATCH_W         5
`define LATCH_PAGE_MSB  4
`define LATCH_PAGE_LSB  3
`define ZERO_BYTE       8'h00
`define ONE_BYTE        8'h01
`define PC_ONE          13'h0001
`define PC_RESET        13'h0000
`define FLAG_SET        1'h1

`endif

// ### design/instr_exec_pkg.sv
// types for the instruction execution subset
`default_nettype none
package instr_exec_pkg;
    // decoded operation class
    typedef enum logic [2:0] {
        OP_NONE,
        OP_GUARD_CLEAR,
        OP_CALL,
        OP_COMPLEMENT,
        OP_CLEAR_REG,
        OP_CLEAR_ACC,
        OP_DECREMENT,
        OP_DEC_SKIP
    } op_kind_t;
    // execution phase
    typedef enum logic [0:0] {
        PH_EXEC,
        PH_FLUSH
    } phase_t;
endpackage : instr_exec_pkg
`default_nettype wire

// ### design/instr_decode.sv
// combinational decode of the instruction word into an operation class
`timescale 1ns/1ps
`default_nettype none
`include "instr_exec_regs.svh"
module instr_decode
    import instr_exec_pkg::*;
(
    input  wire logic [`IW_WIDTH-1:0] i_instr,   // fetched instruction word
    output op_kind_t                  o_kind     // decoded class
);
    logic [5:0] op6;  // upper six bits
    logic [2:0] op3;  // upper three bits
    assign op6 = i_instr[`IW_OP6_MSB:`IW_OP6_LSB];
    assign op3 = i_instr[`IW_OP3_MSB:`IW_OP3_LSB];

    // classify; clear with dest 0 is the accumulator clear
    always_comb begin
        o_kind = OP_NONE;
        if (i_instr == `IW_GUARD_CLEAR) begin
            o_kind = OP_GUARD_CLEAR;
        end else if (op3 == `OP3_CALL) begin
            o_kind = OP_CALL;
        end else if (op6 == `OP6_CLEAR) begin
            o_kind = i_instr[`IW_DEST_BIT] ? OP_CLEAR_REG : OP_CLEAR_ACC;
        end else if (op6 == `OP6_COMPLEMENT) begin
            o_kind = OP_COMPLEMENT;
        end else if (op6 == `OP6_DECREMENT) begin
            o_kind = OP_DECREMENT;
        end else if (op6 == `OP6_DEC_SKIP) begin
            o_kind = OP_DEC_SKIP;
        end
    end
endmodule : instr_decode
`default_nettype wire

// ### design/instr_exec.sv
// execution stage for a subset of an 8-bit core instruction set
// Notes on behaviour
// - guard clear zeroes timer and prescaler
// - guard clear sets expiry and sleep flags
// - subroutine jump pushes pc plus one
// - jump loads k and page latch bits
// - jump takes two cycles, flags kept
// - complement inverts register, updates zero only
// - dest bit zero accumulator, one register
// - register clear writes zero, sets zero
// - decrement stores result, updates zero only
// - accumulator clear zeroes it, sets zero
// - decrement skip on zero flushes next
// - nonzero result runs next normally
`timescale 1ns/1ps
`default_nettype none
`include "instr_exec_regs.svh"
module instr_exec
    import instr_exec_pkg::*;
(
    input  wire logic [`IW_WIDTH-1:0] i_instr,          // instruction word from fetch
    input  wire logic                 i_instr_valid,    // word valid this cycle
    input  wire logic [`DATA_W-1:0]   i_file_rdata,     // addressed register contents
    input  wire logic [`LATCH_W-1:0]  i_page_latch_high,// page latch register
    input  wire logic                 i_mclk,           // core clock
    input  wire logic                 i_rst,            // sync reset, high
    output logic [`FADDR_W-1:0]       o_file_addr,      // file read/write address
    output logic                      o_file_we,        // file write strobe
    output logic [`DATA_W-1:0]        o_file_wdata,     // file write data
    output logic [`DATA_W-1:0]        o_acc,            // accumulator
    output logic                      o_zero_flag,      // result-null flag
    output logic                      o_guard_expiry_flag, // expiry status bit
    output logic                      o_sleep_entry_flag,  // power-down status bit
    output logic                      o_guard_timer_clear, // timer and prescaler clear
    output logic [`PC_W-1:0]          o_pc,             // program counter
    output logic                      o_stack_push,     // push strobe
    output logic [`PC_W-1:0]          o_stack_head,     // value pushed
    output logic                      o_busy            // second cycle in progress
);
    op_kind_t               kind;      // decoded class
    logic                   dest;      // destination select
    logic [`DATA_W-1:0]     dec_val;   // register minus one
    logic                   exec;      // instruction executes this cycle
    phase_t                 ph_q, ph_d;
    logic [`DATA_W-1:0]     acc_q, acc_d;
    logic                   z_q, z_d;
    logic                   to_q, to_d;
    logic                   pd_q, pd_d;
    logic [`PC_W-1:0]       pc_q, pc_d;
    logic                   we_d, we_q;
    logic [`DATA_W-1:0]     wd_d, wd_q;
    logic                   gclr_d, gclr_q;
    logic                   push_d, push_q;
    logic [`PC_W-1:0]       head_d, head_q;

    // operation classifier
    instr_decode u_decode (
        .i_instr (i_instr),
        .o_kind  (kind)
    );

    assign dest    = i_instr[`IW_DEST_BIT];
    assign dec_val = i_file_rdata - `ONE_BYTE;
    assign exec    = i_instr_valid && (ph_q == PH_EXEC);
    // address presented combinationally so the read data is current
    assign o_file_addr = i_instr[`IW_FADDR_MSB:`IW_FADDR_LSB];

    // next-state for all execution state
    always_comb begin
        ph_d   = PH_EXEC;
        acc_d  = acc_q;
        z_d    = z_q;
        to_d   = to_q;
        pd_d   = pd_q;
        pc_d   = pc_q;
        we_d   = 1'b0;
        wd_d   = wd_q;
        gclr_d = 1'b0;
        push_d = 1'b0;
        head_d = head_q;
        if (exec) begin
            pc_d = pc_q + `PC_ONE;
            unique case (kind)
                OP_GUARD_CLEAR: begin
                    gclr_d = 1'b1;
                    to_d   = `FLAG_SET;
                    pd_d   = `FLAG_SET;
                end
                OP_CALL: begin
                    push_d = 1'b1;
                    head_d = pc_q + `PC_ONE;
                    pc_d   = {i_page_latch_high[`LATCH_PAGE_MSB:`LATCH_PAGE_LSB],
                              i_instr[`IW_K11_MSB:`IW_K11_LSB]};
                    ph_d   = PH_FLUSH;
                end
                OP_COMPLEMENT: begin
                    z_d = (~i_file_rdata == `ZERO_BYTE);
                    if (dest == `DEST_FILE) begin
                        we_d = 1'b1;
                        wd_d = ~i_file_rdata;
                    end else begin
                        acc_d = ~i_file_rdata;
                    end
                end
                OP_CLEAR_REG: begin
                    we_d = 1'b1;
                    wd_d = `ZERO_BYTE;
                    z_d  = `FLAG_SET;
                end
                OP_CLEAR_ACC: begin
                    acc_d = `ZERO_BYTE;
                    z_d   = `FLAG_SET;
                end
                OP_DECREMENT: begin
                    z_d = (dec_val == `ZERO_BYTE);
                    if (dest == `DEST_FILE) begin
                        we_d = 1'b1;
                        wd_d = dec_val;
                    end else begin
                        acc_d = dec_val;
                    end
                end
                OP_DEC_SKIP: begin
                    if (dest == `DEST_FILE) begin
                        we_d = 1'b1;
                        wd_d = dec_val;
                    end else begin
                        acc_d = dec_val;
                    end
                    // zero result flushes the next word; nonzero runs it
                    if (dec_val == `ZERO_BYTE) begin
                        ph_d = PH_FLUSH;
                    end else begin
                        ph_d = PH_EXEC;
                    end
                end
                OP_NONE: begin
                    // other instructions lie outside this block
                end
            endcase
        end else if (ph_q == PH_FLUSH && i_instr_valid) begin
            // the discarded word acts as a no-op but still advances the pc
            pc_d = pc_q + `PC_ONE;
        end else if (ph_q == PH_FLUSH) begin
            ph_d = PH_FLUSH;
        end
    end

    // state registers
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ph_q   <= PH_EXEC;
            acc_q  <= `ZERO_BYTE;
            z_q    <= 1'b0;
            to_q   <= `FLAG_SET;
            pd_q   <= `FLAG_SET;
            pc_q   <= `PC_RESET;
            we_q   <= 1'b0;
            wd_q   <= `ZERO_BYTE;
            gclr_q <= 1'b0;
            push_q <= 1'b0;
            head_q <= `PC_RESET;
        end else begin
            ph_q   <= ph_d;
            acc_q  <= acc_d;
            z_q    <= z_d;
            to_q   <= to_d;
            pd_q   <= pd_d;
            pc_q   <= pc_d;
            we_q   <= we_d;
            wd_q   <= wd_d;
            gclr_q <= gclr_d;
            push_q <= push_d;
            head_q <= head_d;
        end
    end

    assign o_file_we           = we_q;
    assign o_file_wdata        = wd_q;
    assign o_acc               = acc_q;
    assign o_zero_flag         = z_q;
    assign o_guard_expiry_flag = to_q;
    assign o_sleep_entry_flag  = pd_q;
    assign o_guard_timer_clear = gclr_q;
    assign o_pc                = pc_q;
    assign o_stack_push        = push_q;
    assign o_stack_head        = head_q;
    assign o_busy              = (ph_q == PH_FLUSH);

    // assertions
    a_guard_clear_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
        exec && kind == OP_GUARD_CLEAR |=> o_guard_timer_clear)
        else $error("guard clear did not pulse timer clear");
    a_guard_flags_set: assert property (@(posedge i_mclk) disable iff (i_rst)
        exec && kind == OP_GUARD_CLEAR |=> o_guard_expiry_flag && o_sleep_entry_flag)
        else $error("guard clear did not set status flags");
    a_call_push_addr: assert property (@(posedge i_mclk) disable iff (i_rst)
        exec && kind == OP_CALL |=> o_stack_push && o_stack_head == $past(pc_q) + `PC_ONE)
        else $error("call pushed wrong return address");
    a_call_target_pc: assert property (@(posedge i_mclk) disable iff (i_rst)
        exec && kind == OP_CALL |=> o_pc == {
            $past(i_page_latch_high[`LATCH_PAGE_MSB:`LATCH_PAGE_LSB]),
            $past(i_instr[`IW_K11_MSB:`IW_K11_LSB])})
        else $error("call loaded wrong target");
    a_call_two_cycle: assert property (@(posedge i_mclk) disable iff (i_rst)
        exec && kind == OP_CALL |=> o_busy && $stable(o_zero_flag))
        else $error("call not two cycles or flags changed");
    a_comp_result_dest: assert property (@(posedge i_mclk) disable iff (i_rst)
        exec && kind == OP_COMPLEMENT && dest |=> o_file_we
            && o_file_wdata == ~$past(i_file_rdata) && o_zero_flag == (o_file_wdata == 8'h00))
        else $error("complement result or zero flag wrong");
    a_dest_acc_route: assert property (@(posedge i_mclk) disable iff (i_rst)
        exec && kind == OP_DECREMENT && !dest |=> !o_file_we
            && o_acc == $past(i_file_rdata) - 8'h01)
        else $error("decrement to accumulator misrouted");
    a_clear_reg_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
        exec && kind == OP_CLEAR_REG |=> o_file_we && o_file_wdata == 8'h00 && o_zero_flag)
        else $error("register clear wrong");
    a_dec_zero_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
        exec && kind == OP_DECREMENT |=> o_zero_flag == ($past(i_file_rdata) == 8'h01))
        else $error("decrement zero flag wrong");
    a_clear_acc_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
        exec && kind == OP_CLEAR_ACC |=> o_acc == 8'h00 && o_zero_flag)
        else $error("accumulator clear wrong");
    a_skip_on_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
        exec && kind == OP_DEC_SKIP && i_file_rdata == 8'h01 |=> o_busy
            && $stable(o_zero_flag))
        else $error("skip not taken on zero");
    a_no_skip_nonzero: assert property (@(posedge i_mclk) disable iff (i_rst)
        exec && kind == OP_DEC_SKIP && i_file_rdata != 8'h01 |=> !o_busy)
        else $error("skip taken on nonzero");
    a_addr_field: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_file_addr == i_instr[`IW_FADDR_MSB:`IW_FADDR_LSB])
        else $error("file address field wrong");

    c_call_seen: cover property (@(posedge i_mclk) exec && kind == OP_CALL);
    c_skip_taken: cover property (@(posedge i_mclk) exec && kind == OP_DEC_SKIP && dec_val == 8'h00);
    c_guard_clear: cover property (@(posedge i_mclk) exec && kind == OP_GUARD_CLEAR);
    c_comp_to_acc: cover property (@(posedge i_mclk) exec && kind == OP_COMPLEMENT && !dest);
endmodule : instr_exec
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the instruction execution subset
`timescale 1ns/1ps
`default_nettype none
`include "instr_exec_regs.svh"
module tb_top;
    // one table row: word, operand, expected write strobe, write data, accumulator, zero flag
    typedef struct packed {
        logic [13:0] instr;
        logic [7:0]  rdata;
        logic        we;
        logic [7:0]  wdata;
        logic [7:0]  acc;
        logic        z;
    } row_t;

    logic                   i_mclk;            // core clock
    logic                   i_rst;             // sync reset
    logic [`IW_WIDTH-1:0]   i_instr;           // word driven as fetch
    logic                   i_instr_valid;     // word present
    logic [`DATA_W-1:0]     i_file_rdata;      // operand returned for o_file_addr
    logic [`LATCH_W-1:0]    i_page_latch_high; // page latch
    logic [`FADDR_W-1:0]    o_file_addr;
    logic                   o_file_we;
    logic [`DATA_W-1:0]     o_file_wdata;
    logic [`DATA_W-1:0]     o_acc;
    logic                   o_zero_flag;
    logic                   o_guard_expiry_flag;
    logic                   o_sleep_entry_flag;
    logic                   o_guard_timer_clear;
    logic [`PC_W-1:0]       o_pc;
    logic                   o_stack_push;
    logic [`PC_W-1:0]       o_stack_head;
    logic                   o_busy;
    int                     num_errors;        // mismatches seen
    int                     cmp_count;         // comparisons made
    logic [`PC_W-1:0]       exp_pc;            // program counter the bench expects

    // ordinary single-cycle cases, run back to back from reset
    row_t rows [9] = '{
        '{14'h0905, 8'h5A, 1'b0, 8'h00, 8'hA5, 1'b0},
        '{14'h09FF, 8'hFF, 1'b1, 8'h00, 8'hA5, 1'b1},
        '{14'h0310, 8'h01, 1'b0, 8'h00, 8'h00, 1'b1},
        '{14'h0391, 8'h00, 1'b1, 8'hFF, 8'h00, 1'b0},
        '{14'h01A2, 8'h33, 1'b1, 8'h00, 8'h00, 1'b1},
        '{14'h0901, 8'h00, 1'b0, 8'h00, 8'hFF, 1'b0},
        '{14'h0100, 8'h77, 1'b0, 8'h00, 8'h00, 1'b1},
        '{14'h0B05, 8'h05, 1'b0, 8'h00, 8'h04, 1'b1},
        '{14'h0B85, 8'h03, 1'b1, 8'h02, 8'h04, 1'b1}
    };

    instr_exec dut (
        .i_instr             (i_instr),
        .i_instr_valid       (i_instr_valid),
        .i_file_rdata        (i_file_rdata),
        .i_page_latch_high   (i_page_latch_high),
        .i_mclk              (i_mclk),
        .i_rst               (i_rst),
        .o_file_addr         (o_file_addr),
        .o_file_we           (o_file_we),
        .o_file_wdata        (o_file_wdata),
        .o_acc               (o_acc),
        .o_zero_flag         (o_zero_flag),
        .o_guard_expiry_flag (o_guard_expiry_flag),
        .o_sleep_entry_flag  (o_sleep_entry_flag),
        .o_guard_timer_clear (o_guard_timer_clear),
        .o_pc                (o_pc),
        .o_stack_push        (o_stack_push),
        .o_stack_head        (o_stack_head),
        .o_busy              (o_busy)
    );

    // free-running clock, 50 ns period
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    // compare seen against expected, count and report
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // drive one word at a falling edge, let one rising edge take it, return at the next fall
    task automatic step(input logic [13:0] w, input logic [7:0] rd, input logic [4:0] lt,
                        input logic v);
        i_instr = w;
        i_file_rdata = rd;
        i_page_latch_high = lt;
        i_instr_valid = v;
        #1;
        if (v) chk(o_file_addr, w[6:0]);
        @(posedge i_mclk);
        @(negedge i_mclk);
    endtask : step

    // print counts and verdict, then stop
    task automatic summarize();
        $display("comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    // hang guard: the whole run is far shorter than this bound
    initial begin
        repeat (5000) @(posedge i_mclk);
        num_errors++;
        $display("ERROR t=%0t run did not finish", $time);
        summarize();
    end

    initial begin
        i_rst = 1'b1;
        i_instr = 14'h0000;
        i_instr_valid = 1'b0;
        i_file_rdata = 8'h00;
        i_page_latch_high = 5'h00;
        num_errors = 0;
        cmp_count = 0;
        repeat (16) @(negedge i_mclk);
        // reset values
        chk(o_acc, 8'h00);
        chk(o_zero_flag, 1'b0);
        chk(o_guard_expiry_flag, 1'b1);
        chk(o_sleep_entry_flag, 1'b1);
        chk(o_pc, 13'h0000);
        chk(o_busy, 1'b0);
        chk(o_stack_push, 1'b0);
        chk(o_file_we, 1'b0);
        i_rst = 1'b0;
        exp_pc = 13'h0000;
        // table of single-cycle operations
        foreach (rows[i]) begin
            step(rows[i].instr, rows[i].rdata, 5'h00, 1'b1);
            exp_pc++;
            chk(o_file_we, rows[i].we);
            if (rows[i].we) chk(o_file_wdata, rows[i].wdata);
            chk(o_acc, rows[i].acc);
            chk(o_zero_flag, rows[i].z);
            chk(o_busy, 1'b0);
            chk(o_pc, exp_pc);
        end
        // guard timer clear pulses once and sets both status bits
        step(14'h0064, 8'h00, 5'h00, 1'b1);
        exp_pc++;
        chk(o_guard_timer_clear, 1'b1);
        chk(o_guard_expiry_flag, 1'b1);
        chk(o_sleep_entry_flag, 1'b1);
        step(14'h0901, 8'h00, 5'h00, 1'b1);
        exp_pc++;
        chk(o_guard_timer_clear, 1'b0);
        chk(o_zero_flag, 1'b0);
        // jump at the top of the immediate range, then the flushed word
        step(14'h27FF, 8'h00, 5'h18, 1'b1);
        chk(o_stack_push, 1'b1);
        chk(o_stack_head, exp_pc + 13'h0001);
        chk(o_pc, 13'h1FFF);
        chk(o_busy, 1'b1);
        chk(o_zero_flag, 1'b0);
        step(14'h0100, 8'h00, 5'h18, 1'b1);
        chk(o_acc, 8'hFF);
        chk(o_zero_flag, 1'b0);
        chk(o_stack_push, 1'b0);
        chk(o_busy, 1'b0);
        chk(o_pc, 13'h0000);
        // only page bits 4:3 of the latch reach the counter
        step(14'h2000, 8'h00, 5'h0F, 1'b1);
        chk(o_pc, 13'h0800);
        chk(o_stack_head, 13'h0001);
        step(14'h0000, 8'h00, 5'h0F, 1'b1);
        exp_pc = 13'h0801;
        // decrement-skip to zero into the file, idle while busy, then flushed word
        step(14'h0B85, 8'h01, 5'h00, 1'b1);
        exp_pc++;
        chk(o_file_we, 1'b1);
        chk(o_file_wdata, 8'h00);
        chk(o_busy, 1'b1);
        chk(o_zero_flag, 1'b0);
        repeat (2) begin
            step(14'h0100, 8'h00, 5'h00, 1'b0);
            chk(o_busy, 1'b1);
            chk(o_file_we, 1'b0);
        end
        step(14'h0100, 8'h00, 5'h00, 1'b1);
        exp_pc++;
        chk(o_acc, 8'hFF);
        chk(o_busy, 1'b0);
        chk(o_pc, exp_pc);
        // decrement-skip to zero into the accumulator, flushed word back to back
        step(14'h0B05, 8'h01, 5'h00, 1'b1);
        chk(o_acc, 8'h00);
        chk(o_zero_flag, 1'b0);
        chk(o_busy, 1'b1);
        step(14'h0100, 8'h00, 5'h00, 1'b1);
        chk(o_zero_flag, 1'b0);
        step(14'h0100, 8'h00, 5'h00, 1'b1);
        chk(o_zero_flag, 1'b1);
        // reset in the middle of a two-cycle jump
        step(14'h2123, 8'h00, 5'h00, 1'b1);
        i_rst = 1'b1;
        step(14'h0000, 8'h00, 5'h00, 1'b0);
        i_rst = 1'b0;
        chk(o_busy, 1'b0);
        chk(o_pc, 13'h0000);
        chk(o_zero_flag, 1'b0);
        step(14'h0100, 8'h00, 5'h00, 1'b1);
        chk(o_pc, 13'h0001);
        chk(o_zero_flag, 1'b1);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
